// *** pkg/gtt_pkg.sv ***
// Purpose: Constants for the global trigger, throttle and timestamp block
// Assumes: Wishbone classic slave with 32-bit data and byte addresses
// Notes: Register words are aligned; config words read back all 32 written bits
package gtt_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MULT = 8'h04;
    localparam logic [7:0] OFS_DERAND = 8'h08;
    localparam logic [7:0] OFS_RULE = 8'h0c;
    localparam logic [7:0] OFS_FCMD = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_TS_LO = 8'h18;
    localparam logic [7:0] OFS_TS_HI = 8'h1c;
    localparam logic [7:0] OFS_THROTTLED = 8'h20;
    // Control bit positions
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_COINC = 1;
    localparam int CTRL_RULE_EN = 2;
    localparam int CTRL_WARN_EN = 3;
    // Field positions
    localparam int DERAND_SVC_LSB = 8;
    localparam int STATUS_OCC_LSB = 16;
    localparam int STATUS_WARN = 24;
    localparam int STATUS_ERR = 25;
    localparam int FCMD_BUSY = 8;
    // Reset values
    localparam logic [31:0] RST_CTRL = 32'h0000_0000;
    localparam logic [31:0] RST_MULT = 32'h0000_0002;
    localparam logic [31:0] RST_DERAND = 32'h0000_0804;
    localparam logic [31:0] RST_RULE = 32'h0000_0064;
    // Fast command codes
    localparam logic [3:0] FC_FAST_RESET = 4'h1;
    localparam logic [3:0] FC_INIT = 4'h2;
    localparam logic [3:0] FC_CALIB = 4'h3;
    localparam logic [3:0] FC_TEST_SEQ = 4'h4;
endpackage : gtt_pkg

// *** core/global_trigger_throttle_timestamp.sv ***
// Purpose: Central trigger validation, accept throttling, timestamps, fast commands
// Assumes: clk_link is the common link clock; clk_sys carries the register bus
// Notes: Config crosses by a toggle without acknowledge, status by a toggle handshake; link inputs pass two flops
//
// The implementer's own choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/10ps
// Functional notes
// - All trigger logic runs on the common link clock that drives the links.
// - A 48-bit timestamp counts every link clock cycle.
// - A 16-bit event number counts each issued level-1 accept.
// - Accepts go out only when the front-ends can take them.
// - A model of the derandomizer queue tracks occupancy per accept.
// - An accept that would overflow the modelled queue is suppressed.
// - Optional rule: at most n accepts within a programmable window.
// - Requests of all crystals form one pattern evaluated every cycle.
// - Validation needs at least a programmed multiplicity of requests.
// - Error reports from front-ends are received and shown to software.
// - Software issues fast, init, calibration and test commands.
module global_trigger_throttle_timestamp #(
    parameter int N_CRYSTALS = 180,
    parameter int RULE_N = 4
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic clk_link,
    input wire logic [N_CRYSTALS-1:0] trig_req,
    input wire logic anc_trig,
    input wire logic [N_CRYSTALS-1:0] buf_warn,
    input wire logic [N_CRYSTALS-1:0] err_report,
    output logic level1_accept,
    output logic [47:0] timestamp,
    output logic [15:0] event_number,
    output logic [3:0] fast_cmd,
    output logic fast_cmd_valid
);
    localparam int CW = $clog2(N_CRYSTALS + 1);
    localparam int PW = (RULE_N > 1) ? $clog2(RULE_N) : 1;

    initial begin
        if (N_CRYSTALS < 1 || N_CRYSTALS > 255 || RULE_N < 1 || RULE_N > 16) begin
            $error("Unsupported crystal count or rule depth");
        end
    end

    // Bus side registers
    logic [31:0] ctrl, mult, derand, rule;
    logic cfg_tgl, fc_tgl, fc_a1, fc_a2, ss1, ss2, ss3;
    logic [3:0] fc_code;
    logic [15:0] st_ev;
    logic [7:0] st_occ;
    logic [47:0] st_ts;
    logic [31:0] st_thr;
    logic st_warn, st_err;

    wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o; // Write lands on the edge the master sees ack
    wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [31:0] wval_ctrl = (ctrl & ~wmask) | (wb_dat_i & wmask);
    wire [31:0] wval_mult = (mult & ~wmask) | (wb_dat_i & wmask);
    wire [31:0] wval_der = (derand & ~wmask) | (wb_dat_i & wmask);
    wire [31:0] wval_rule = (rule & ~wmask) | (wb_dat_i & wmask);
    wire wr_ctrl = wr && wb_adr_i == gtt_pkg::OFS_CTRL;
    wire wr_mult = wr && wb_adr_i == gtt_pkg::OFS_MULT;
    wire wr_der = wr && wb_adr_i == gtt_pkg::OFS_DERAND;
    wire wr_rule = wr && wb_adr_i == gtt_pkg::OFS_RULE;
    wire fc_busy = fc_tgl != fc_a2;
    // Commands written while one is in flight are dropped, never merged
    wire wr_fc = wr && wb_adr_i == gtt_pkg::OFS_FCMD && wb_sel_i[0] && !fc_busy;
    wire [31:0] status_word = {6'h00, st_err, st_warn, st_occ, st_ev};
    // Read decode; unmapped addresses answer with zero
    wire [31:0] rd_word =
        (wb_adr_i == gtt_pkg::OFS_CTRL) ? ctrl :
        (wb_adr_i == gtt_pkg::OFS_MULT) ? mult :
        (wb_adr_i == gtt_pkg::OFS_DERAND) ? derand :
        (wb_adr_i == gtt_pkg::OFS_RULE) ? rule :
        (wb_adr_i == gtt_pkg::OFS_FCMD) ? {23'h000000, fc_busy, 4'h0, fc_code} :
        (wb_adr_i == gtt_pkg::OFS_STATUS) ? status_word :
        (wb_adr_i == gtt_pkg::OFS_TS_LO) ? st_ts[31:0] :
        (wb_adr_i == gtt_pkg::OFS_TS_HI) ? {16'h0000, st_ts[47:32]} :
        (wb_adr_i == gtt_pkg::OFS_THROTTLED) ? st_thr : 32'h0000_0000;

    // Answer one cycle after the request; ack drops on the next edge
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? rd_word : 32'h0000_0000;
        end
    end

    // Configuration words; any write announces new settings to the link side
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl <= gtt_pkg::RST_CTRL;
            mult <= gtt_pkg::RST_MULT;
            derand <= gtt_pkg::RST_DERAND;
            rule <= gtt_pkg::RST_RULE;
            cfg_tgl <= 1'b0;
        end else begin
            if (wr_ctrl) ctrl <= wval_ctrl;
            if (wr_mult) mult <= wval_mult;
            if (wr_der) derand <= wval_der;
            if (wr_rule) rule <= wval_rule;
            if (wr_ctrl || wr_mult || wr_der || wr_rule) cfg_tgl <= !cfg_tgl;
        end
    end

    // Fast command launch by toggle, acknowledged back from the link side
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            fc_tgl <= 1'b0;
            fc_code <= 4'h0;
        end else if (wr_fc) begin
            fc_code <= wb_dat_i[3:0];
            fc_tgl <= !fc_tgl;
        end
    end

    // Status snapshot capture; the handshake keeps the words stable meanwhile
    logic [15:0] sn_ev;
    logic [7:0] sn_occ;
    logic [47:0] sn_ts;
    logic [31:0] sn_thr;
    logic sn_warn, sn_err, sn_tgl, fc_s3;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            {ss1, ss2, ss3, fc_a1, fc_a2} <= 5'h00;
            st_ev <= 16'h0000;
            st_occ <= 8'h00;
            st_ts <= 48'h0000_0000_0000;
            st_thr <= 32'h0000_0000;
            {st_warn, st_err} <= 2'h0;
        end else begin
            {ss1, ss2, ss3} <= {sn_tgl, ss1, ss2};
            {fc_a1, fc_a2} <= {fc_s3, fc_a1};
            if (ss2 != ss3) begin
                st_ev <= sn_ev;
                st_occ <= sn_occ;
                st_ts <= sn_ts;
                st_thr <= sn_thr;
                st_warn <= sn_warn;
                st_err <= sn_err;
            end
        end
    end

    // Link reset: asserted at once, released on the link clock
    logic rst_l1, rst_l;
    always_ff @(posedge clk_link or posedge rst) begin
        if (rst) {rst_l1, rst_l} <= 2'h3;
        else {rst_l1, rst_l} <= {1'b0, rst_l1};
    end

    // Two-flop synchronisers for link inputs and crossing toggles
    logic [N_CRYSTALS-1:0] tr1, tr_s, wn1, wn_s, er1, er_s;
    logic an1, an_s, cs1, cs2, cs3, fc_s1, fc_s2, la1, la2;
    always_ff @(posedge clk_link or posedge rst_l) begin
        if (rst_l) begin
            {tr1, tr_s, wn1, wn_s, er1, er_s} <= '0;
            {an1, an_s, cs1, cs2, cs3, fc_s1, fc_s2, fc_s3, la1, la2} <= 10'h000;
        end else begin
            {tr1, tr_s} <= {trig_req, tr1};
            {wn1, wn_s} <= {buf_warn, wn1};
            {er1, er_s} <= {err_report, er1};
            {an1, an_s} <= {anc_trig, an1};
            {cs1, cs2, cs3} <= {cfg_tgl, cs1, cs2};
            {fc_s1, fc_s2, fc_s3} <= {fc_tgl, fc_s1, fc_s2};
            {la1, la2} <= {ss3, la1};
        end
    end

    // Link copies of the settings, taken when the toggle announces a change
    logic en, coinc, rule_en, warn_en;
    logic [7:0] c_mult, c_depth;
    logic [15:0] c_svc, c_win;
    always_ff @(posedge clk_link or posedge rst_l) begin
        if (rst_l) begin
            {en, coinc, rule_en, warn_en} <= gtt_pkg::RST_CTRL[3:0];
            c_mult <= gtt_pkg::RST_MULT[7:0];
            c_depth <= gtt_pkg::RST_DERAND[7:0];
            c_svc <= gtt_pkg::RST_DERAND[gtt_pkg::DERAND_SVC_LSB +: 16];
            c_win <= gtt_pkg::RST_RULE[15:0];
        end else if (cs2 != cs3) begin
            en <= ctrl[gtt_pkg::CTRL_ENABLE];
            coinc <= ctrl[gtt_pkg::CTRL_COINC];
            rule_en <= ctrl[gtt_pkg::CTRL_RULE_EN];
            warn_en <= ctrl[gtt_pkg::CTRL_WARN_EN];
            c_mult <= mult[7:0];
            c_depth <= derand[7:0];
            c_svc <= derand[gtt_pkg::DERAND_SVC_LSB +: 16];
            c_win <= rule[15:0];
        end
    end

    // Request count of the whole pattern, one adder per crystal
    logic [CW-1:0] psum [0:N_CRYSTALS];
    assign psum[0] = '0;
    genvar gi;
    generate
        for (gi = 0; gi < N_CRYSTALS; gi++) begin : g_pop
            assign psum[gi+1] = psum[gi] + CW'(tr_s[gi]);
        end
    endgenerate

    // Throttle model state
    logic cand;
    logic [7:0] occ;
    logic [15:0] svc_cnt;
    logic [15:0] ring [0:RULE_N-1];
    logic [PW-1:0] rptr;
    logic [4:0] fill;
    logic [31:0] thr_cnt;
    wire fc_new = fc_s2 != fc_s3;
    wire fast_rst = fc_new && fc_code == gtt_pkg::FC_FAST_RESET;
    wire [7:0] mult_cnt = 8'(psum[N_CRYSTALS]);
    wire next_cand = en && mult_cnt >= c_mult && (!coinc || an_s);
    wire svc_done = 17'(svc_cnt) + 17'h00001 >= 17'(c_svc);
    wire pop = occ != 8'h00 && svc_done;
    wire room = (occ - 8'(pop)) < c_depth;
    wire [15:0] age = timestamp[15:0] - ring[rptr];
    wire rule_ok = !rule_en || fill < 5'(RULE_N) || age >= c_win;
    wire warn_ok = !warn_en || !(|wn_s);
    wire allow = room && rule_ok && warn_ok;
    wire accept_now = cand && allow && !fast_rst;

    // Validation, accept and timestamp pipeline on the common clock
    always_ff @(posedge clk_link or posedge rst_l) begin
        if (rst_l) begin
            cand <= 1'b0;
            level1_accept <= 1'b0;
            timestamp <= 48'h0000_0000_0000;
            event_number <= 16'h0000;
        end else begin
            cand <= next_cand;
            level1_accept <= accept_now;
            timestamp <= fast_rst ? 48'h0000_0000_0000 : timestamp + 48'h0000_0000_0001;
            if (fast_rst) event_number <= 16'h0000;
            else if (level1_accept) event_number <= event_number + 16'h0001;
        end
    end

    // Derandomizer emulation: fixed service time per queued event
    always_ff @(posedge clk_link or posedge rst_l) begin
        if (rst_l) begin
            occ <= 8'h00;
            svc_cnt <= 16'h0000;
        end else if (fast_rst) begin
            occ <= 8'h00;
            svc_cnt <= 16'h0000;
        end else begin
            occ <= occ + 8'(accept_now) - 8'(pop);
            svc_cnt <= (occ == 8'h00 || pop) ? 16'h0000 : svc_cnt + 16'h0001;
        end
    end

    // Ring of recent accept times for the n-in-window rule
    always_ff @(posedge clk_link or posedge rst_l) begin
        if (rst_l) begin
            rptr <= '0;
            fill <= 5'h00;
            for (int i = 0; i < RULE_N; i++) ring[i] <= 16'h0000;
        end else if (fast_rst) begin
            rptr <= '0;
            fill <= 5'h00;
        end else if (accept_now) begin
            ring[rptr] <= timestamp[15:0];
            rptr <= (32'(rptr) == RULE_N - 1) ? '0 : rptr + PW'(1);
            if (fill < 5'(RULE_N)) fill <= fill + 5'h01;
        end
    end

    // Fast command issue, one-cycle strobe; throttled count; status snapshot
    // The snapshot lags live state by a few cycles, fine for monitoring
    always_ff @(posedge clk_link or posedge rst_l) begin
        if (rst_l) begin
            fast_cmd <= 4'h0;
            fast_cmd_valid <= 1'b0;
            thr_cnt <= 32'h0000_0000;
            sn_tgl <= 1'b0;
            sn_ev <= 16'h0000;
            sn_occ <= 8'h00;
            sn_ts <= 48'h0000_0000_0000;
            sn_thr <= 32'h0000_0000;
            {sn_warn, sn_err} <= 2'h0;
        end else begin
            fast_cmd_valid <= fc_new;
            if (fc_new) fast_cmd <= fc_code;
            if (cand && !allow) thr_cnt <= thr_cnt + 32'h0000_0001;
            if (la2 == sn_tgl) begin
                sn_tgl <= !sn_tgl;
                sn_ev <= event_number;
                sn_occ <= occ;
                sn_ts <= timestamp;
                sn_thr <= thr_cnt;
                sn_warn <= |wn_s;
                sn_err <= |er_s;
            end
        end
    end

    // Checks
    sequence s_cand_ok;
        cand && allow && !fast_rst;
    endsequence
    sequence s_full;
        cand && !room;
    endsequence
    a_ts_step: assert property (@(posedge clk_link) disable iff (rst_l)
        !fast_rst |=> timestamp == $past(timestamp) + 48'h0000_0000_0001)
        else $error("timestamp did not advance");
    a_event_count: assert property (@(posedge clk_link) disable iff (rst_l)
        level1_accept && !fast_rst |=> event_number == $past(event_number) + 16'h0001)
        else $error("event number missed an accept");
    a_accept_issue: assert property (@(posedge clk_link) disable iff (rst_l)
        s_cand_ok |=> level1_accept)
        else $error("allowed validation not accepted");
    a_throttle_full: assert property (@(posedge clk_link) disable iff (rst_l)
        s_full |=> !level1_accept)
        else $error("accept issued into full queue");
    a_occ_track: assert property (@(posedge clk_link) disable iff (rst_l)
        !fast_rst && !pop && accept_now |=> occ == $past(occ) + 8'h01)
        else $error("occupancy not raised by accept");
    a_rule_window: assert property (@(posedge clk_link) disable iff (rst_l)
        rule_en && fill == 5'(RULE_N) && age < c_win |=> !level1_accept)
        else $error("accept broke the window rule");
    a_mult_valid: assert property (@(posedge clk_link) disable iff (rst_l)
        en && !coinc && mult_cnt >= c_mult |=> cand)
        else $error("multiplicity met without validation");
    a_fast_reset: assert property (@(posedge clk_link) disable iff (rst_l)
        fast_rst |=> timestamp == 48'h0000_0000_0000 && event_number == 16'h0000 ##1 fast_cmd_valid == 1'b0)
        else $error("fast reset did not clear counters");
    a_fcmd_pulse: assert property (@(posedge clk_link) disable iff (rst_l)
        fast_cmd_valid |=> !fast_cmd_valid)
        else $error("fast command strobe too long");
    a_wb_ack_drop: assert property (@(posedge clk_sys) disable iff (rst)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
endmodule : global_trigger_throttle_timestamp

// *** verification/crystal_frontend_model.sv ***
// Purpose: Behavioural crystal front-ends driving request, warning and error lines
// Assumes: All lines change just after a rising link clock edge
// Notes: Dead time after an accept mutes requests, as the real front-ends do
`timescale 1ns/10ps
module crystal_frontend_model #(
    parameter int N = 180,
    parameter int DEAD = 3
) (
    input wire logic clk_link,
    input wire logic rst,
    input wire logic level1_accept,
    input wire logic [7:0] fire_n,
    input wire logic anc_on,
    input wire logic warn_on,
    input wire logic err_on,
    output logic [N-1:0] trig_req,
    output logic anc_trig,
    output logic [N-1:0] buf_warn,
    output logic [N-1:0] err_report
);
    logic [3:0] dead;

    // First fire_n crystals request; a crystal still dead after an accept stays quiet
    always_ff @(posedge clk_link or posedge rst) begin
        if (rst) begin
            trig_req <= '0;
            anc_trig <= 1'b0;
            buf_warn <= '0;
            err_report <= '0;
            dead <= 4'h0;
        end else begin
            for (int i = 0; i < N; i++) begin
                trig_req[i] <= (i < int'(fire_n)) && (dead == 4'h0);
            end
            anc_trig <= anc_on;
            buf_warn <= {N{warn_on}};
            err_report <= {N{err_on}};
            dead <= level1_accept ? 4'(DEAD) : ((dead != 4'h0) ? dead - 4'h1 : 4'h0);
        end
    end
endmodule : crystal_frontend_model

// *** verification/global_trigger_throttle_timestamp_tb.sv ***
// Purpose: Self-checking bench for trigger validation, throttling and timestamps
// Assumes: Bus on clk_sys at 4 ns, link clock 48 ns with unrelated phase
// Notes: Reset also spans three link edges so the link side sees it
`timescale 1ns/10ps
module global_trigger_throttle_timestamp_tb;
    localparam int N_CRY = 180;
    localparam int RULE_N = 4;
    logic clk_sys, clk_link, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, anc_trig, level1_accept, fast_cmd_valid;
    logic anc_on, warn_on, err_on;
    logic [7:0] wb_adr_i, fire_n;
    logic [3:0] wb_sel_i, fast_cmd;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    logic [N_CRY-1:0] trig_req, buf_warn, err_report;
    logic [47:0] timestamp;
    logic [15:0] event_number;
    int miscompares = 0;
    int n_checks = 0;
    int n_acc = 0;

    global_trigger_throttle_timestamp #(.N_CRYSTALS(N_CRY), .RULE_N(RULE_N)) dut_u (
        .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .clk_link(clk_link), .trig_req(trig_req), .anc_trig(anc_trig), .buf_warn(buf_warn),
        .err_report(err_report), .level1_accept(level1_accept), .timestamp(timestamp),
        .event_number(event_number), .fast_cmd(fast_cmd), .fast_cmd_valid(fast_cmd_valid));
    crystal_frontend_model #(.N(N_CRY), .DEAD(3)) frontend_u (
        .clk_link(clk_link), .rst(rst), .level1_accept(level1_accept), .fire_n(fire_n), .anc_on(anc_on),
        .warn_on(warn_on), .err_on(err_on), .trig_req(trig_req), .anc_trig(anc_trig), .buf_warn(buf_warn),
        .err_report(err_report));

    // Clocks; the link clock starts off-phase so edges never coincide by design
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    initial begin
        clk_link = 1'b0;
        #7;
        forever #24 clk_link = ~clk_link;
    end
    // Accept pulses tallied in the link domain
    always @(posedge clk_link) begin
        if (level1_accept === 1'b1) n_acc <= n_acc + 1;
    end

    task chk(input string name, input logic [47:0] exp, input logic [47:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // Classic cycle: hold the request until ack is sampled, then drop for a cycle
    task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        // No cycle count assumed; a missing ack is left to the watchdog
        do begin
            @(posedge clk_sys);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_sys);
    endtask : wb
    task link(input int n);
        repeat (n) @(posedge clk_link);
    endtask : link
    // Config crosses in a few link cycles, so every write is given time to land
    task cfg(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
        link(6);
    endtask : cfg
    task fire(input logic [7:0] n, input logic a, input int exp_acc);
        int a0;
        a0 = n_acc;
        @(posedge clk_link);
        fire_n <= n;
        anc_on <= a;
        @(posedge clk_link);
        fire_n <= 8'h00;
        anc_on <= 1'b0;
        link(12);
        chk("accepts", 48'(exp_acc), 48'(n_acc - a0));
    endtask : fire

    task t_regs();
        wb(1'b0, gtt_pkg::OFS_CTRL, 32'h0);
        chk("ctrl", 48'(gtt_pkg::RST_CTRL), 48'(q));
        wb(1'b0, gtt_pkg::OFS_MULT, 32'h0);
        chk("mult", 48'(gtt_pkg::RST_MULT), 48'(q));
        wb(1'b0, gtt_pkg::OFS_DERAND, 32'h0);
        chk("derand", 48'(gtt_pkg::RST_DERAND), 48'(q));
        wb(1'b0, gtt_pkg::OFS_RULE, 32'h0);
        chk("rule", 48'(gtt_pkg::RST_RULE), 48'(q));
        wb(1'b1, 8'h24, 32'hffff_ffff);
        wb(1'b0, 8'h24, 32'h0);
        chk("unmapped", 48'h0, 48'(q));
    endtask : t_regs
    task t_mult();
        logic [15:0] ev;
        cfg(gtt_pkg::OFS_CTRL, 32'h0000_0001);
        ev = event_number;
        fire(8'h01, 1'b0, 0);
        fire(8'h02, 1'b0, 1);
        chk("event_number", 48'(ev + 16'h0001), 48'(event_number));
        cfg(gtt_pkg::OFS_MULT, 32'h0000_001e);
        fire(8'h1d, 1'b0, 0);
        fire(8'h1e, 1'b0, 1);
        cfg(gtt_pkg::OFS_MULT, 32'h0000_0002);
        cfg(gtt_pkg::OFS_CTRL, 32'h0000_0003);
        fire(8'h02, 1'b0, 0);
        fire(8'h02, 1'b1, 1);
    endtask : t_mult
    task t_ts();
        logic [47:0] t0;
        repeat (3) begin
            @(posedge clk_link);
            t0 = timestamp;
            @(posedge clk_link);
            chk("timestamp", t0 + 48'h1, timestamp);
        end
    endtask : t_ts
    // Every command code in turn; fast reset first so its clearing can be seen
    task t_fcmd();
        logic [3:0] codes[4];
        codes = '{gtt_pkg::FC_FAST_RESET, gtt_pkg::FC_INIT, gtt_pkg::FC_CALIB, gtt_pkg::FC_TEST_SEQ};
        foreach (codes[k]) begin
            wb(1'b1, gtt_pkg::OFS_FCMD, {28'h0, codes[k]});
            while (fast_cmd_valid !== 1'b1) begin
                @(posedge clk_link);
            end
            chk("fast_cmd", 48'(codes[k]), 48'(fast_cmd));
            link(2);
            if (k == 0) begin
                chk("event_cleared", 48'h0, 48'(event_number));
                chk("ts_cleared", 48'h1, 48'(timestamp < 48'h28));
            end
            link(8);
        end
        wb(1'b0, gtt_pkg::OFS_FCMD, 32'h0);
        chk("fcmd_readback", 48'(gtt_pkg::FC_TEST_SEQ), 48'(q));
    endtask : t_fcmd
    // Depth one, service 200: the second accept must be held back until a pop
    task t_derand();
        logic [31:0] th0;
        cfg(gtt_pkg::OFS_CTRL, 32'h0000_0001);
        cfg(gtt_pkg::OFS_DERAND, 32'h0000_c801);
        wb(1'b0, gtt_pkg::OFS_THROTTLED, 32'h0);
        th0 = q;
        fire(8'h02, 1'b0, 1);
        fire(8'h02, 1'b0, 0);
        wb(1'b0, gtt_pkg::OFS_THROTTLED, 32'h0);
        chk("throttled", 48'(th0 + 32'h1), 48'(q));
        link(220);
        fire(8'h02, 1'b0, 1);
        cfg(gtt_pkg::OFS_DERAND, 32'h0000_0108);
    endtask : t_derand
    task t_rule();
        // Empty the accept ring first; earlier accepts would otherwise fill the window
        wb(1'b1, gtt_pkg::OFS_FCMD, {28'h0, gtt_pkg::FC_FAST_RESET});
        link(6);
        cfg(gtt_pkg::OFS_RULE, 32'h0000_03e8);
        cfg(gtt_pkg::OFS_CTRL, 32'h0000_0005);
        repeat (RULE_N) fire(8'h02, 1'b0, 1);
        fire(8'h02, 1'b0, 0);
        link(1000);
        fire(8'h02, 1'b0, 1);
    endtask : t_rule
    task t_warn();
        cfg(gtt_pkg::OFS_CTRL, 32'h0000_0009);
        @(posedge clk_link);
        warn_on <= 1'b1;
        link(6);
        fire(8'h02, 1'b0, 0);
        wb(1'b0, gtt_pkg::OFS_STATUS, 32'h0);
        chk("status_warn", 48'h1, 48'(q[gtt_pkg::STATUS_WARN]));
        @(posedge clk_link);
        warn_on <= 1'b0;
        err_on <= 1'b1;
        link(8); // Snapshot runs every third link cycle, so allow for the slowest one
        wb(1'b0, gtt_pkg::OFS_STATUS, 32'h0);
        chk("status_err", 48'h1, 48'(q[gtt_pkg::STATUS_ERR]));
        @(posedge clk_link);
        err_on <= 1'b0;
        link(6);
        fire(8'h02, 1'b0, 1);
    endtask : t_warn

    task complete_run();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : complete_run
    // Watchdog sized well above the roughly 80 us the scenarios need
    initial begin
        #300000;
        miscompares++;
        complete_run();
    end
    // Main sequence
    initial begin
        rst = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, anc_on, warn_on, err_on} = 6'h00;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hf;
        wb_dat_i = 32'h0;
        fire_n = 8'h00;
        repeat (4) @(posedge clk_sys);
        repeat (3) @(posedge clk_link);
        @(posedge clk_sys);
        rst <= 1'b0;
        link(4);
        t_regs();
        t_mult();
        t_ts();
        t_fcmd();
        t_derand();
        t_rule();
        t_warn();
        complete_run();
    end
endmodule : global_trigger_throttle_timestamp_tb
